// >>> design/iopc_top.sv
// interrupt output stage: master line, deassertion pacing and pin control
//
// Function
// - interval field counts in 10 us units
// - zero interval disables pacing, releases held interrupts
// - new interval takes effect at once, also on an interval in progress
// - power event wake never held back
// - restart bit begins fresh interval, self-clears
// - during interval flag set, pin withheld except for power event wake
// - outside interval flag clear, interrupts pass
// - master bit mirrors any enabled active source
// - master ignores pin enable and pacing
// - pin enable clear keeps pin deasserted
// - pin enable gates only the pin
// - push-pull polarity selects active low or high
// - type bit selects open drain or push-pull
// - open drain ignores polarity, active low
`timescale 1ns/1ps
`include "iopc_defs.svh"

module iopc_top
    import iopc_pkg::*;
#(
    parameter int NUM_SRC = 32,
    parameter int PME_BIT = 17,
    parameter int TICK_CYCLES = `IOPC_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`IOPC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [NUM_SRC-1:0] source_status_register,
    input wire logic [NUM_SRC-1:0] source_enable,
    output logic master_irq,
    output logic irq_pin_o,
    output logic irq_pin_oe_n
);

    // ==========================================================
    // elaboration checks
    generate
        if (NUM_SRC < 1 || NUM_SRC > 32) begin : g_bad_num
            $error("iopc_top: NUM_SRC must be 1 to 32");
        end
        if (PME_BIT < 0 || PME_BIT >= NUM_SRC) begin : g_bad_pme
            $error("iopc_top: PME_BIT must address a source");
        end
    endgenerate

    // ==========================================================
    // configuration register
    iopc_interval_t irq_pacing_interval_reg;
    logic pin_enable_reg;
    logic pin_polarity_select_reg;
    logic buffer_push_pull_reg;

    wire cfg_hit = (reg_addr == `IOPC_CFG_OFFSET);
    wire cfg_wr = reg_wr_en && cfg_hit;
    wire cfg_rd = reg_rd_en && cfg_hit;
    wire iopc_interval_t wr_interval = reg_wdata[`IOPC_INTERVAL_HI:`IOPC_INTERVAL_LO];
    wire pacing_restart = cfg_wr && reg_wdata[`IOPC_RESTART_BIT];
    wire interval_zero_wr = cfg_wr && (wr_interval == 8'h00);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_pacing_interval_reg <= `IOPC_INTERVAL_RESET;
            pin_enable_reg <= 1'b0;
            pin_polarity_select_reg <= 1'b0;
            buffer_push_pull_reg <= 1'b0;
        end else if (cfg_wr) begin
            irq_pacing_interval_reg <= wr_interval;
            pin_enable_reg <= reg_wdata[`IOPC_PIN_EN_BIT];
            pin_polarity_select_reg <= reg_wdata[`IOPC_POL_BIT];
            buffer_push_pull_reg <= reg_wdata[`IOPC_TYPE_BIT];
        end
    end

    // ==========================================================
    // source combination
    logic [NUM_SRC-1:0] src_live;
    logic [NUM_SRC-1:0] src_paced;
    logic pacing_active_flag;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            assign src_live[gi] = source_status_register[gi] && source_enable[gi];
            if (gi == PME_BIT) begin : g_pme
                assign src_paced[gi] = src_live[gi];
            end else begin : g_norm
                assign src_paced[gi] = src_live[gi] && !pacing_active_flag;
            end
        end
    endgenerate

    // internal line follows enabled sources only, pin enable and pacing play no part
    wire master_next = |src_live;
    wire paced_line = |src_paced;
    // pin enable gates only the pin path
    wire pin_asserted_next = paced_line && pin_enable_reg;

    logic pin_asserted_reg;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            master_irq <= 1'b0;
            pin_asserted_reg <= 1'b0;
        end else begin
            master_irq <= master_next;
            pin_asserted_reg <= pin_asserted_next;
        end
    end

    // ==========================================================
    // 10 us tick
    logic tick;
    iopc_state_e state_reg;
    iopc_state_e state_next;

    wire fresh_start;

    iopc_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .restart(fresh_start),
        .tick(tick)
    );

    // ==========================================================
    // pacing state machine
    iopc_interval_t units_reg;
    iopc_interval_t units_next;

    // interval to use: the value being written takes effect at once
    wire iopc_interval_t live_interval = cfg_wr ? wr_interval : irq_pacing_interval_reg;
    wire pin_fall = pin_asserted_reg && !pin_asserted_next;
    wire start_on_fall = pin_fall && (state_reg == IOPC_PASS);
    assign fresh_start = (pacing_restart || start_on_fall) && (live_interval != 8'h00);
    wire units_done = tick && ((units_reg + 8'h01) >= live_interval);

    always_comb begin
        state_next = state_reg;
        units_next = units_reg;
        case (state_reg)
            IOPC_PASS: begin
                if (fresh_start) begin
                    state_next = IOPC_HOLD;
                    units_next = 8'h00;
                end
            end
            IOPC_HOLD: begin
                if (interval_zero_wr) begin
                    state_next = IOPC_PASS;
                    units_next = 8'h00;
                end else if (pacing_restart) begin
                    units_next = 8'h00;
                end else if (units_done) begin
                    state_next = IOPC_PASS;
                    units_next = 8'h00;
                end else if (tick) begin
                    units_next = units_reg + 8'h01;
                end
            end
            default: begin
                state_next = IOPC_PASS;
                units_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg <= IOPC_PASS;
            units_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            units_reg <= units_next;
        end
    end

    assign pacing_active_flag = (state_reg == IOPC_HOLD);

    // ==========================================================
    // pin driver
    iopc_pin_driver u_pin (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .irq_asserted(pin_asserted_reg),
        .push_pull(buffer_push_pull_reg),
        .pin_polarity_select(pin_polarity_select_reg),
        .irq_pin_o(irq_pin_o),
        .irq_pin_oe_n(irq_pin_oe_n)
    );

    // ==========================================================
    // read data: restart bit reads zero, reserved bits read zero
    logic [31:0] cfg_view;

    always_comb begin
        cfg_view = 32'h0000_0000;
        cfg_view[`IOPC_INTERVAL_HI:`IOPC_INTERVAL_LO] = irq_pacing_interval_reg;
        cfg_view[`IOPC_ACTIVE_BIT] = pacing_active_flag;
        cfg_view[`IOPC_MASTER_BIT] = master_irq;
        cfg_view[`IOPC_PIN_EN_BIT] = pin_enable_reg;
        cfg_view[`IOPC_POL_BIT] = pin_polarity_select_reg;
        cfg_view[`IOPC_TYPE_BIT] = buffer_push_pull_reg;
    end

    wire [31:0] rdata_next = cfg_rd ? cfg_view : 32'h0000_0000;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

endmodule // iopc_top

// >>> design/iopc_defs.svh
// register offset, field positions, reset values and timing counts for the irq pacing block
`ifndef IOPC_DEFS_SVH
`define IOPC_DEFS_SVH

// ==========================================================
// register map
`define IOPC_CFG_OFFSET 8'h54
`define IOPC_ADDR_W 8

// ==========================================================
// field positions of interrupt_output_config
`define IOPC_INTERVAL_HI 31
`define IOPC_INTERVAL_LO 24
`define IOPC_RESTART_BIT 14
`define IOPC_ACTIVE_BIT 13
`define IOPC_MASTER_BIT 12
`define IOPC_PIN_EN_BIT 8
`define IOPC_POL_BIT 4
`define IOPC_TYPE_BIT 0

// ==========================================================
// reset values
`define IOPC_CFG_RESET 32'h0000_0000
`define IOPC_INTERVAL_RESET 8'h00

// ==========================================================
// timing: one interval unit is 10 us, clock period 10 ns
`define IOPC_UNIT_US 10
`define IOPC_CLK_PERIOD_NS 10
`define IOPC_TICK_CYCLES ((`IOPC_UNIT_US * 1000) / `IOPC_CLK_PERIOD_NS)

`endif

// >>> design/iopc_pkg.sv
// types shared by the irq pacing block
package iopc_pkg;

    // ==========================================================
    // pacing state, gray coded
    typedef enum logic [0:0] {
        IOPC_PASS = 1'b0,
        IOPC_HOLD = 1'b1
    } iopc_state_e;

    typedef logic [7:0] iopc_interval_t;

endpackage

// >>> design/iopc_tick_gen.sv
// divider that makes the one-cycle 10 us pacing tick
`timescale 1ns/1ps
`include "iopc_defs.svh"

module iopc_tick_gen #(
    parameter int TICK_CYCLES = `IOPC_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic restart,
    output logic tick
);

    localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] div_reg;
    logic [CW-1:0] div_next;
    logic tick_next;
    wire at_last = (div_reg == LAST);

    generate
        if (TICK_CYCLES < 2) begin : g_bad
            $error("iopc_tick_gen: TICK_CYCLES must be at least 2");
        end
    endgenerate

    assign div_next = (restart || at_last) ? '0 : div_reg + CW'(1);
    assign tick_next = at_last && !restart;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            div_reg <= '0;
            tick <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick <= tick_next;
        end
    end

endmodule // iopc_tick_gen

// >>> design/iopc_pin_driver.sv
// drives the interrupt pin as open drain or push-pull with selectable polarity
`timescale 1ns/1ps

module iopc_pin_driver (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic irq_asserted,
    input wire logic push_pull,
    input wire logic pin_polarity_select,
    output logic irq_pin_o,
    output logic irq_pin_oe_n
);

    logic pin_next;
    logic oe_n_next;

    // open drain pulls low only while asserted and ignores polarity
    // push-pull drives always, active high only when polarity is set
    assign pin_next = push_pull ? (pin_polarity_select ? irq_asserted : !irq_asserted) : 1'b0;
    assign oe_n_next = push_pull ? 1'b0 : !irq_asserted;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_pin_o <= 1'b0;
            irq_pin_oe_n <= 1'b1;
        end else begin
            irq_pin_o <= pin_next;
            irq_pin_oe_n <= oe_n_next;
        end
    end

endmodule // iopc_pin_driver

// >>> dv/iopc_top_props.sv
// assertions on the ports of the irq pacing block
`timescale 1ns/1ps
`include "iopc_defs.svh"
module iopc_top_props #(
    parameter int NUM_SRC = 32,
    parameter int PME_BIT = 17,
    parameter int TICK_CYCLES = 1000
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [`IOPC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [NUM_SRC-1:0] source_status_register,
    input wire logic [NUM_SRC-1:0] source_enable,
    input wire logic master_irq,
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe_n
);
// ==========
// config shadow; quiet once config has settled for three cycles
logic [7:0] ivl;
logic en, pol, pp, pme_q, pme_q2;
logic [1:0] cnt;
wire cfg_wr = reg_wr_en && reg_addr == `IOPC_CFG_OFFSET;
wire quiet = cnt == 2'h3;
wire pme_on = source_status_register[PME_BIT] & source_enable[PME_BIT];
wire pin_on = pp ? irq_pin_o == pol : !irq_pin_oe_n;
always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
        {ivl, en, pol, pp, pme_q, pme_q2, cnt} <= '0;
    end else begin
        pme_q <= pme_on;
        pme_q2 <= pme_q;
        cnt <= cfg_wr ? 2'h0 : (quiet ? cnt : cnt + 2'h1);
        if (cfg_wr) begin
            {ivl, en, pol, pp} <= {reg_wdata[31:24], reg_wdata[8], reg_wdata[4], reg_wdata[0]};
        end
    end
end
default clocking @(posedge sys_clk); endclocking
default disable iff (!reset_n);
sequence s_pin_fall;
    $fell(pin_on) && en && ivl != 8'h00 && quiet;
endsequence
sequence s_held;
    (!pin_on || pme_on || pme_q || pme_q2)[*8];
endsequence
AST_MASTER: assert property ($past(reset_n, 2) |->
    master_irq == $past(|(source_status_register & source_enable))) else $error("master bad");
AST_RD_VIEW: assert property (reg_rd_en && reg_addr == `IOPC_CFG_OFFSET |=>
    (reg_rdata & 32'h00ffceee) == 32'h0) else $error("reserved or restart bit read set");
AST_RD_UNMAPPED: assert property (reg_rd_en && reg_addr != `IOPC_CFG_OFFSET |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
AST_PIN_OFF: assert property (quiet && !en |-> !pin_on) else $error("pin on");
AST_OD_LOW: assert property (quiet && !pp |-> !irq_pin_o) else $error("od high");
AST_PP_DRIVE: assert property (quiet && pp |-> !irq_pin_oe_n) else $error("pp off");
AST_PASS: assert property (quiet && en && ivl == 8'h00 && master_irq |=> pin_on)
    else $error("interrupt not passed");
AST_HOLD: assert property (s_pin_fall |=> s_held) else $error("pin not held");
endmodule // iopc_top_props
bind iopc_top iopc_top_props #(.NUM_SRC(NUM_SRC), .PME_BIT(PME_BIT), .TICK_CYCLES(TICK_CYCLES))
    u_props (.sys_clk, .reset_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .source_status_register, .source_enable, .master_irq, .irq_pin_o, .irq_pin_oe_n);

// >>> dv/iopc_host_model.sv
// host side: pulled-up interrupt input and source status register
`timescale 1ns/1ps
module iopc_host_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe_n,
    input wire logic [31:0] set_bits,
    input wire logic [31:0] clr_bits,
    output logic irq_line,
    output logic [31:0] status
);
// ==========
// pull-up holds the line high once released
assign irq_line = irq_pin_oe_n ? 1'b1 : irq_pin_o;
always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
        status <= '0;
    end else begin
        status <= (status | set_bits) & ~clr_bits;
    end
end
endmodule // iopc_host_model

// >>> dv/tb.sv
// testbench for the irq pacing block
`timescale 1ns/1ps
`include "iopc_defs.svh"
module tb;
localparam int TK = 10;
logic sys_clk = 0, reset_n = 0, reg_wr_en = 0, reg_rd_en = 0, irq_line;
logic [`IOPC_ADDR_W-1:0] reg_addr = 8'h00;
logic [31:0] reg_wdata = 32'h0, reg_rdata, set_bits = 32'h0, clr_bits = 32'h0, status;
logic [31:0] source_enable = 32'hffff_ffdf;
logic master_irq, irq_pin_o, irq_pin_oe_n;
int mismatches = 0, samples_checked = 0, cyc = 0, t0;
iopc_top #(.TICK_CYCLES(TK)) DUT (.sys_clk, .reset_n, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wdata, .reg_rdata, .source_status_register(status), .source_enable, .master_irq,
    .irq_pin_o, .irq_pin_oe_n);
iopc_host_model u_host (.sys_clk, .reset_n, .irq_pin_o, .irq_pin_oe_n, .set_bits,
    .clr_bits, .irq_line, .status);
initial forever #5 sys_clk = ~sys_clk;
always @(posedge sys_clk) cyc <= cyc + 1;
// ==========
// access tasks
task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        mismatches++;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
endtask
task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
endtask
task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_wr_en = 1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr_en = 0;
endtask
task automatic rd(logic [7:0] a, logic [31:0] e);
    reg_rd_en = 1;
    reg_addr = a;
    tick(1);
    reg_rd_en = 0;
    check("reg_rdata", reg_rdata, e);
endtask
task automatic pulse(logic [31:0] s, logic [31:0] c);
    set_bits = s;
    clr_bits = c;
    tick(1);
    set_bits = 0;
    clr_bits = 0;
endtask
task automatic wait_line(logic v, int lim);
    for (int n = 0; n < lim && irq_line !== v; n++) tick(1);
    check("irq_line", irq_line, v);
endtask
function automatic logic span(int d, int n);
    return d >= n * TK - 3 && d <= n * TK + 5;
endfunction
task automatic pace(logic [7:0] ivl);
    wr(8'h54, {ivl, 24'h000100});
    tick(3);
    pulse(0, 32'h8);
    wait_line(1, 5);
    t0 = cyc;
    pulse(32'h8, 0);
    tick(4);
    rd(8'h54, {ivl, 24'h003100});
    check("held", irq_line, 1);
    wait_line(0, ivl * TK + 20);
    check("hold_len", span(cyc - t0, ivl), 1);
endtask
task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
initial begin
    #200000;
    mismatches++;
    give_verdict();
end
// ==========
// tests
initial begin
    tick(2);
    reset_n = 1;
    rd(8'h54, 32'h0);
    check("oe_n", irq_pin_oe_n, 1);
    $display("done: reset");
    wr(8'h54, 32'hffff_ffff);
    rd(8'h54, 32'hff00_2111);
    wr(8'h58, 32'h0);
    rd(8'h58, 32'h0);
    rd(8'h54, 32'hff00_2111);
    wr(8'h54, 32'h0);
    rd(8'h54, 32'h0);
    $display("done: registers");
    pulse(32'h20, 0);
    tick(3);
    check("master", master_irq, 0);
    pulse(32'h8, 0);
    tick(3);
    rd(8'h54, 32'h1000);
    check("line", irq_line, 1);
    for (int i = 0; i < 4; i++) begin
        wr(8'h54, 32'h100 | 32'(i[1]) << 4 | 32'(i[0]));
        tick(4);
        check("on", irq_line, i[0] ? i[1] : 1'b0);
        pulse(0, 32'h8);
        tick(4);
        check("off", irq_line, i[0] ? !i[1] : 1'b1);
        pulse(32'h8, 0);
    end
    $display("done: pin modes");
    pace(8'h02);
    pace(8'h04);
    $display("done: pacing");
    pulse(0, 32'h8);
    wait_line(1, 5);
    pulse(32'h8, 0);
    tick(20);
    wr(8'h54, 32'h0400_4100);
    t0 = cyc;
    wait_line(0, 80);
    check("restart_len", span(cyc - t0, 4), 1);
    pulse(0, 32'h8);
    wait_line(1, 5);
    pulse(32'h8, 0);
    tick(2);
    pulse(32'h2_0000, 0);
    wait_line(0, 4);
    pulse(0, 32'h2_0000);
    wait_line(1, 4);
    tick(9);
    wr(8'h54, 32'h100);
    wait_line(0, 4);
    rd(8'h54, 32'h1100);
    $display("done: restart, wake, zero");
    give_verdict();
end
endmodule // tb
